/* hw/nesl_pkg.sv */
// Purpose: constants for the NIC event status and interrupt request logic
// Assumes: APB slave with 32-bit data, one word per register
// Notes: event status keeps its printed offset as an index, byte address is 4x
package nesl_pkg;
   localparam int NESL_ADDR_W = 8;
   localparam logic [7:0] NESL_IDX_STATUS = 8'h07;
   localparam logic [7:0] NESL_IDX_MASK = 8'h0f;
   localparam logic [7:0] NESL_IDX_COMMAND = 8'h00;
   localparam logic [7:0] NESL_IDX_RESET_SRC = 8'h10;
   localparam logic [7:0] NESL_ADDR_STATUS = 8'h1c;
   localparam logic [7:0] NESL_ADDR_MASK = 8'h3c;
   localparam logic [7:0] NESL_ADDR_COMMAND = 8'h00;
   localparam logic [7:0] NESL_ADDR_RESET_SRC = 8'h40;
   localparam int NESL_BIT_RX_OK = 0;
   localparam int NESL_BIT_TX_OK = 1;
   localparam int NESL_BIT_RX_ERR = 2;
   localparam int NESL_BIT_TX_ERR = 3;
   localparam int NESL_BIT_OVERWRITE = 4;
   localparam int NESL_BIT_TALLY = 5;
   localparam int NESL_BIT_DMA_DONE = 6;
   localparam int NESL_BIT_RESET_STATE = 7;
   localparam int NESL_CMD_STOP_BIT = 0;
   localparam int NESL_CMD_ACTIVATE_BIT = 1;
   localparam logic [7:0] NESL_MASK_RESET = 8'h00;
   localparam logic [7:0] NESL_STATUS_RESET = 8'h80;
   localparam logic [6:0] NESL_CLEARABLE = 7'h7f;
   localparam logic [1:0] NESL_COMMAND_RESET = 2'h1;
endpackage

/* hw/nesl_flag.sv */
// Purpose: one write-one-to-clear event flag
// Assumes: set and clear are single-cycle strobes
// Notes: set wins over a clear in the same cycle
`timescale 1ns/1ns
`default_nettype none
module nesl_flag
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set,
   input wire logic clear,
   output logic flag
);
   logic next_flag;

   always_comb
   begin
      next_flag = flag;
      if (clear)
      begin
         next_flag = 1'b0;
      end
      if (set)
      begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag <= 1'b0;
      end
      else
      begin
         flag <= next_flag;
      end
   end
endmodule
`default_nettype wire

/* hw/nesl_top.sv */
// Purpose: event status flags, mask and host interrupt of a NIC
// Assumes: event inputs are one-cycle strobes synchronous to pclk
// Notes: APB slave, zero wait states, unmapped addresses read zero, no error
// Operation
// - Writing one clears flags 0 to 6
// - Interrupt high while any unmasked flag set
// - Flags 0 to 6 individually maskable
// - Bit 0 set on good receive
// - Bit 1 set on good transmit
// - Bit 2 set on receive error
// - Bit 3 set on transmit error
// - Bit 4 set when ring exhausted
// - Bit 5 set on tally counter MSB
// - Bit 6 set when host DMA completes
// - Bit 7 set on reset, cleared by start
// - Bit 7 set on ring overflow, cleared by removal
// - Host writes to bit 7 ignored
// - Bit 7 never raises the interrupt
// - Mask bit enables matching flag
// - Mask powers up all zero
`timescale 1ns/1ns
`default_nettype none
module nesl_top
   import nesl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [nesl_pkg::NESL_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic packet_rx_ok,
   input wire logic packet_tx_ok,
   input wire logic rx_crc_error,
   input wire logic rx_align_error,
   input wire logic rx_fifo_overrun,
   input wire logic rx_missed_packet,
   input wire logic tx_excess_collisions,
   input wire logic tx_fifo_underrun,
   input wire logic ring_exhausted,
   input wire logic tally_msb_set,
   input wire logic host_dma_done,
   input wire logic ring_overflow,
   input wire logic ring_packet_removed,
   output logic host_irq,
   output logic running
);
   import nesl_pkg::*;

   logic [6:0] event_set;
   logic [6:0] event_clear;
   logic [6:0] event_flags;
   logic [7:0] event_mask_register;
   logic [7:0] next_mask;
   logic [1:0] command_register;
   logic [1:0] next_command;
   logic reset_state;
   logic next_reset_state;
   logic ring_full;
   logic next_ring_full;
   logic [31:0] next_prdata;
   logic wr_access;
   logic rd_access;
   logic start_cmd;
   logic stop_cmd;
   logic [7:0] status_view;
   logic wr_status;
   logic wr_mask;
   logic wr_command;
   logic next_host_irq;
   logic next_running;
   logic [6:0] irq_sources;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction

   // Register strobe: access phase write on lane 0 to one address
   function automatic logic lane0_write(input logic acc, input logic [3:0] strb,
      input logic [7:0] addr, input logic [7:0] reg_addr);
      lane0_write = acc && strb[0] && hit(addr, reg_addr);
   endfunction

   assign wr_access = psel && penable && pwrite;
   assign rd_access = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_status = lane0_write(wr_access, pstrb, paddr, NESL_ADDR_STATUS);
   assign wr_mask = lane0_write(wr_access, pstrb, paddr, NESL_ADDR_MASK);
   assign wr_command = lane0_write(wr_access, pstrb, paddr, NESL_ADDR_COMMAND);

   always_comb
   begin
      event_set = '0;
      event_set[NESL_BIT_RX_OK] = packet_rx_ok;
      event_set[NESL_BIT_TX_OK] = packet_tx_ok;
      event_set[NESL_BIT_RX_ERR] = rx_crc_error | rx_align_error | rx_fifo_overrun
         | rx_missed_packet;
      event_set[NESL_BIT_TX_ERR] = tx_excess_collisions | tx_fifo_underrun;
      event_set[NESL_BIT_OVERWRITE] = ring_exhausted;
      event_set[NESL_BIT_TALLY] = tally_msb_set;
      event_set[NESL_BIT_DMA_DONE] = host_dma_done;
   end

   // Only a low byte write with strobe can clear; bit 7 excluded
   assign event_clear = wr_status ? (pwdata[6:0] & NESL_CLEARABLE) : 7'h00;

   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++)
      begin : g_flag
         // Set has priority inside the flag cell
         nesl_flag u_flag
         (
            .pclk(pclk),
            .presetn(presetn),
            .set(event_set[gi]),
            .clear(event_clear[gi]),
            .flag(event_flags[gi])
         );
      end
   endgenerate

   assign start_cmd = wr_command && pwdata[NESL_CMD_ACTIVATE_BIT];
   assign stop_cmd = wr_command && pwdata[NESL_CMD_STOP_BIT];

   // Command bits kept as written so software can read them back
   always_comb
   begin
      next_command = command_register;
      if (wr_command)
      begin
         next_command = pwdata[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         command_register <= NESL_COMMAND_RESET;
      end
      else
      begin
         command_register <= next_command;
      end
   end

   // Stop wins when both command bits are written together
   always_comb
   begin
      next_reset_state = reset_state;
      if (stop_cmd)
      begin
         next_reset_state = 1'b1;
      end
      else if (start_cmd)
      begin
         next_reset_state = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reset_state <= NESL_STATUS_RESET[NESL_BIT_RESET_STATE];
      end
      else
      begin
         reset_state <= next_reset_state;
      end
   end

   // Overflow beats removal so a fresh overflow is never lost
   always_comb
   begin
      next_ring_full = ring_full;
      if (ring_packet_removed)
      begin
         next_ring_full = 1'b0;
      end
      if (ring_overflow)
      begin
         next_ring_full = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ring_full <= 1'b0;
      end
      else
      begin
         ring_full <= next_ring_full;
      end
   end

   // Mask bit 7 has no flag behind it, so it always reads zero
   always_comb
   begin
      next_mask = event_mask_register;
      if (wr_mask)
      begin
         next_mask = {1'b0, pwdata[6:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         event_mask_register <= NESL_MASK_RESET;
      end
      else
      begin
         event_mask_register <= next_mask;
      end
   end

   assign status_view = {reset_state | ring_full, event_flags};

   // Read data launched in setup, so access phase is zero-wait
   always_comb
   begin
      next_prdata = prdata;
      if (rd_access)
      begin
         next_prdata = 32'h0000_0000;
         if (hit(paddr, NESL_ADDR_STATUS))
         begin
            next_prdata[7:0] = status_view;
         end
         else if (hit(paddr, NESL_ADDR_MASK))
         begin
            next_prdata[7:0] = event_mask_register;
         end
         else if (hit(paddr, NESL_ADDR_COMMAND))
         begin
            next_prdata[1:0] = command_register;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else
      begin
         prdata <= next_prdata;
      end
   end

   // Bit 7 left out of the product
   assign irq_sources = event_flags & event_mask_register[6:0];

   // Registered so the pin never glitches while flags settle
   always_comb
   begin
      next_host_irq = |irq_sources;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         host_irq <= 1'b0;
      end
      else
      begin
         host_irq <= next_host_irq;
      end
   end

   // Follows the run state in the same cycle as the command write
   always_comb
   begin
      next_running = ~next_reset_state;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         running <= 1'b0;
      end
      else
      begin
         running <= next_running;
      end
   end
endmodule
`default_nettype wire

/* verif/nesl_monitor.sv */
// Purpose: bound checker for the event status block
// Assumes: zero wait state APB, one-cycle event pulses
// Notes: sees top ports only
`timescale 1ns/1ns
`default_nettype none
module nesl_monitor
   import nesl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic packet_rx_ok,
   input wire logic host_irq,
   input wire logic running
);
   wire logic wr = psel && penable && pwrite && pstrb[0];
   wire logic rd = psel && !penable && !pwrite;
   wire logic wr_st = wr && paddr == NESL_ADDR_STATUS;
   wire logic wr_cmd = wr && paddr == NESL_ADDR_COMMAND;
   wire logic rd_st = rd && paddr == NESL_ADDR_STATUS;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   irq_fall_a: assert property ($fell(host_irq) |-> $past(wr, 2))
      else $error("irq fell without a write");
   rx_flag_a: assert property (packet_rx_ok && !wr ##2 rd_st |=> prdata[0])
      else $error("receive flag not set");
   set_wins_a: assert property (packet_rx_ok && wr_st ##2 rd_st |=> prdata[0])
      else $error("clear beat set");
   flag_clear_a: assert property (
      wr_st && pwdata[0] && !packet_rx_ok ##1 !packet_rx_ok ##1 rd_st |=> !prdata[0])
      else $error("flag not cleared");
   start_run_a: assert property (wr_cmd && pwdata[1:0] == 2'h2 |-> ##[1:2] running)
      else $error("start ignored");
   stop_halt_a: assert property (wr_cmd && pwdata[0] |-> ##[1:2] !running)
      else $error("stop ignored");
   mask_read_a: assert property (
      wr && paddr == NESL_ADDR_MASK ##2 rd && paddr == NESL_ADDR_MASK
      |=> prdata[7:0] == {1'b0, $past(pwdata[6:0], 3)}) else $error("mask readback");
   mask_zero_a: assert property (wr && paddr == NESL_ADDR_MASK && pwdata[6:0] == 7'h00
      |-> ##2 !host_irq [*2]) else $error("irq with all masked");
   cover property (wr_st && packet_rx_ok);
   cover property ($fell(host_irq));
   cover property ($rose(running));
endmodule
bind nesl_top nesl_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .packet_rx_ok(packet_rx_ok), .host_irq(host_irq), .running(running));
`default_nettype wire

/* verif/testbench.sv */
// Purpose: self-checking bench for the event status block
// Assumes: APB master releases after pready, one idle cycle between transfers
// Notes: each scenario is its own task
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
   import nesl_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, host_irq, running;
   logic err_seen = 1'b0;
   logic [12:0] ev = 13'h0;
   int failures = 0;
   int checks_done = 0;
   always #25 pclk = ~pclk;
   nesl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .packet_rx_ok(ev[0]), .packet_tx_ok(ev[1]),
      .rx_crc_error(ev[2]), .rx_align_error(ev[3]), .rx_fifo_overrun(ev[4]),
      .rx_missed_packet(ev[5]), .tx_excess_collisions(ev[6]), .tx_fifo_underrun(ev[7]),
      .ring_exhausted(ev[8]), .tally_msb_set(ev[9]), .host_dma_done(ev[10]),
      .ring_overflow(ev[11]), .ring_packet_removed(ev[12]), .host_irq(host_irq),
      .running(running));
   // Events ride in the access cycle so a clear can meet a set
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [12:0] p = 13'h0);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      ev <= p;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      ev <= 13'h0;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(string n, logic [7:0] a, logic [7:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(n, {24'h0, e}, rd)
      `CHK("no error", 1'b0, err_seen)
   endtask
   task automatic pulse(logic [12:0] p);
      apb(1'b0, 8'h08, 32'h0, p);
      @(posedge pclk);
   endtask
   function automatic logic [7:0] fbit(int i);
      return 8'h1 << (i < 2 ? i : i < 6 ? 2 : i < 8 ? 3 : i - 4);
   endfunction
   task automatic t_events;
      rchk("status rst", NESL_ADDR_STATUS, 8'h80);
      rchk("mask rst", NESL_ADDR_MASK, 8'h00);
      apb(1'b1, NESL_ADDR_STATUS, 32'hff);
      rchk("bit7 kept", NESL_ADDR_STATUS, 8'h80);
      for (int i = 0; i < 11; i++)
      begin
         apb(1'b0, 8'h08, 32'h0, 13'h1 << i);
         rchk("event", NESL_ADDR_STATUS, 8'h80 | fbit(i));
         `CHK("irq off", 1'b0, host_irq)
         apb(1'b1, NESL_ADDR_STATUS, {24'h0, fbit(i)});
         rchk("cleared", NESL_ADDR_STATUS, 8'h80);
      end
      apb(1'b1, NESL_ADDR_STATUS, 32'h1, 13'h1);
      rchk("set wins", NESL_ADDR_STATUS, 8'h81);
      apb(1'b1, NESL_ADDR_STATUS, 32'h1);
   endtask
   task automatic t_irq;
      apb(1'b1, NESL_ADDR_COMMAND, 32'h2);
      rchk("started", NESL_ADDR_STATUS, 8'h00);
      `CHK("running", 1'b1, running)
      rchk("command", NESL_ADDR_COMMAND, 8'h02);
      apb(1'b1, NESL_ADDR_MASK, 32'h05);
      rchk("mask", NESL_ADDR_MASK, 8'h05);
      pulse(13'h2);
      `CHK("masked", 1'b0, host_irq)
      pulse(13'h5);
      `CHK("irq set", 1'b1, host_irq)
      apb(1'b1, NESL_ADDR_STATUS, 32'h1);
      rchk("partial", NESL_ADDR_STATUS, 8'h06);
      `CHK("irq held", 1'b1, host_irq)
      apb(1'b1, NESL_ADDR_STATUS, 32'h4);
      rchk("reread", NESL_ADDR_STATUS, 8'h02);
      `CHK("irq drop", 1'b0, host_irq)
   endtask
   task automatic t_bit7;
      apb(1'b1, NESL_ADDR_STATUS, 32'hff);
      apb(1'b1, NESL_ADDR_MASK, 32'hff);
      rchk("mask7", NESL_ADDR_MASK, 8'h7f);
      pulse(13'h800);
      rchk("overflow", NESL_ADDR_STATUS, 8'h80);
      `CHK("bit7 irq", 1'b0, host_irq)
      pulse(13'h1000);
      rchk("removed", NESL_ADDR_STATUS, 8'h00);
      pulse(13'h400);
      `CHK("dma irq", 1'b1, host_irq)
      apb(1'b1, NESL_ADDR_MASK, 32'h0);
      @(posedge pclk);
      `CHK("all masked", 1'b0, host_irq)
      apb(1'b1, NESL_ADDR_COMMAND, 32'h1);
      rchk("stopped", NESL_ADDR_STATUS, 8'hc0);
      `CHK("halted", 1'b0, running)
   endtask
   task automatic end_sim;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_events;
      t_irq;
      t_bit7;
      end_sim;
   end
   // Run needs about 240 cycles
   initial
   begin
      #200000;
      failures++;
      end_sim;
   end
endmodule
`default_nettype wire
